/* design/pio_map.vh */
// Constants for the shared parallel I/O port: offsets, masks, resets.
// Assumes a 16-bit register port with 8-bit addresses.
`ifndef PIO_MAP_VH
`define PIO_MAP_VH

// Register offsets
`define OFS_FIRST_DIR      8'h00
`define OFS_FIRST_LAT      8'h02
`define OFS_FIRST_LVL      8'h04
`define OFS_SHRD_DIR       8'h06
`define OFS_SHRD_LAT       8'h08
`define OFS_SHRD_LVL       8'h0A
`define OFS_ANA_CFG        8'h0C

// Width of each port
`define PORT_W             16

// First port field positions
`define FIRST_GP_LSB       0
`define FIRST_GP_MSB       7
`define FIRST_INT_LSB      8
`define FIRST_INT_MSB      11
`define FIRST_VREF_LSB     12
`define FIRST_VREF_MSB     13

// Implemented bits; absent bits read as zero
`define FIRST_IMPL_MASK    16'h3FFF
`define SHRD_IMPL_MASK     16'hFFFF

// Reset values
`define DIR_RST_INPUT      16'hFFFF
`define LAT_RST            16'h0000
`define ANA_RST            16'h0000
`define RDATA_RST          16'h0000
`define PAD_OE_RST         16'h0000
`define PERIPH_IN_RST      16'h0000
`define INT_LVL_RST        4'h0

// The first port carries no analog inputs
`define FIRST_ANA_MASK     16'h0000

`endif

/* design/shared_parallel_io_port.v */
// Shared parallel I/O port: a dedicated first port and a shared port
// with peripheral override and analog pin configuration.
// Assumes pad cells resolve pad_out/pad_oe, and that peripheral
// control inputs come from logic on ref_clk.
// Reads answer in the cycle after the strobe; writes never stall the bus.
//
// Operation
// - Every shared port pin shared with peripheral functions
// - Driving peripheral disables port driver, readable
// - Enabled idle peripheral lets latch drive pin
// - Direction bit one means input
// - Reset makes every pin an input
// - Latch read returns latch, write updates
// - Level read returns pins, write hits latch
// - Unimplemented bits read zero everywhere
// - Input-only shared pin treated as dedicated
// - First direction register covers interrupt, reference
// - Peripheral-first mux for pad data, enable
// - Analog-configured pins read zero at level
// - Digital inputs not routed to converter
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "pio_map.vh"
`default_nettype none

module shared_parallel_io_port (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Register port
  input  wire [7:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [15:0] rdata,
  // First port pads (dedicated)
  input  wire [15:0] first_pad_in,
  output reg  [15:0] first_pad_out,
  output reg  [15:0] first_pad_oe,
  // External interrupt pin levels
  output reg  [3:0]  ext_int_level,
  // Shared port pads
  input  wire [15:0] shrd_pad_in,
  output reg  [15:0] shrd_pad_out,
  output reg  [15:0] shrd_pad_oe,
  // Peripheral side of the shared port
  input  wire [15:0] periph_en,
  input  wire [15:0] periph_drive,
  input  wire [15:0] periph_out,
  output reg  [15:0] periph_in,
  // Analog converter routing
  output reg  [15:0] analog_route
);

  // Level read: synchronised pins, absent and analog bits as zero
  function [15:0] level_val;
    input [15:0] pins;
    input [15:0] mask;
    input [15:0] ana;
    begin
      level_val = pins & mask & ~ana;
    end
  endfunction

  // Pad enable for a port bit: driven only while direction is output
  function [15:0] port_oe;
    input [15:0] dir;
    input [15:0] mask;
    begin
      port_oe = ~dir & mask;
    end
  endfunction

  // Write data with absent bits forced to zero
  function [15:0] masked_wr;
    input [15:0] data;
    input [15:0] mask;
    begin
      masked_wr = data & mask;
    end
  endfunction

  // Owned bits take the peripheral's value, the rest the port's
  function [15:0] own_mux;
    input [15:0] own;
    input [15:0] periph_val;
    input [15:0] port_val;
    begin
      own_mux = (own & periph_val) | (~own & port_val);
    end
  endfunction

  reg [15:0] first_dir_r;
  reg [15:0] first_dir_nxt;
  reg [15:0] first_lat_r;
  reg [15:0] first_lat_nxt;
  reg [15:0] shrd_dir_r;
  reg [15:0] shrd_dir_nxt;
  reg [15:0] shrd_lat_r;
  reg [15:0] shrd_lat_nxt;
  reg [15:0] ana_cfg_r;
  reg [15:0] ana_cfg_nxt;
  reg [15:0] rdata_nxt;

  // Two-stage synchronisers; stage one feeds only stage two
  reg [15:0] first_s1_r;
  reg [15:0] first_s2_r;
  reg [15:0] shrd_s1_r;
  reg [15:0] shrd_s2_r;

  reg [15:0] first_oe_nxt;
  reg [15:0] shrd_out_nxt;
  reg [15:0] shrd_oe_nxt;
  reg [15:0] shrd_own;

  // Write decode; a write to a level offset lands in that port's latch
  reg         wr_first_dir;
  reg         wr_first_lat;
  reg         wr_shrd_dir;
  reg         wr_shrd_lat;
  reg         wr_ana;

  always @* begin
    wr_first_dir = 1'h0;
    wr_first_lat = 1'h0;
    wr_shrd_dir  = 1'h0;
    wr_shrd_lat  = 1'h0;
    wr_ana       = 1'h0;
    if (wr_stb) begin
      case (addr)
        `OFS_FIRST_DIR: wr_first_dir = 1'h1;
        `OFS_FIRST_LAT: wr_first_lat = 1'h1;
        `OFS_FIRST_LVL: wr_first_lat = 1'h1;
        `OFS_SHRD_DIR:  wr_shrd_dir  = 1'h1;
        `OFS_SHRD_LAT:  wr_shrd_lat  = 1'h1;
        `OFS_SHRD_LVL:  wr_shrd_lat  = 1'h1;
        `OFS_ANA_CFG:   wr_ana       = 1'h1;
        default:        wr_ana       = 1'h0;
      endcase
    end
  end

  // Level views for reads: synchronised pins, absent and analog bits zero
  wire [15:0] first_lvl;
  wire [15:0] shrd_lvl;

  assign first_lvl = level_val(first_s2_r, `FIRST_IMPL_MASK, `FIRST_ANA_MASK);
  assign shrd_lvl  = level_val(shrd_s2_r, `SHRD_IMPL_MASK, ana_cfg_r);

  // No reset here: two edges of reset flush both stages anyway
  always @(posedge ref_clk) begin
    first_s1_r <= first_pad_in;
    first_s2_r <= first_s1_r;
  end

  always @(posedge ref_clk) begin
    shrd_s1_r <= shrd_pad_in;
    shrd_s2_r <= shrd_s1_r;
  end

  // Register writes; absent bits never store a one
  always @* begin
    first_dir_nxt = first_dir_r;
    first_lat_nxt = first_lat_r;
    shrd_dir_nxt  = shrd_dir_r;
    shrd_lat_nxt  = shrd_lat_r;
    ana_cfg_nxt   = ana_cfg_r;
    if (wr_first_dir) begin
      // One register sets general, interrupt and reference pins alike
      first_dir_nxt = masked_wr(wdata, `FIRST_IMPL_MASK);
    end
    if (wr_first_lat) begin
      first_lat_nxt = masked_wr(wdata, `FIRST_IMPL_MASK);
    end
    if (wr_shrd_dir) begin
      shrd_dir_nxt = masked_wr(wdata, `SHRD_IMPL_MASK);
    end
    if (wr_shrd_lat) begin
      shrd_lat_nxt = masked_wr(wdata, `SHRD_IMPL_MASK);
    end
    if (wr_ana) begin
      ana_cfg_nxt = masked_wr(wdata, `SHRD_IMPL_MASK);
    end
  end

  // Read data stands in the cycle after the strobe only
  always @* begin
    rdata_nxt = `RDATA_RST;
    if (rd_stb) begin
      case (addr)
        `OFS_FIRST_DIR: rdata_nxt = first_dir_r;
        `OFS_FIRST_LAT: rdata_nxt = first_lat_r;
        `OFS_FIRST_LVL: rdata_nxt = first_lvl;
        `OFS_SHRD_DIR:  rdata_nxt = shrd_dir_r;
        `OFS_SHRD_LAT:  rdata_nxt = shrd_lat_r;
        `OFS_SHRD_LVL:  rdata_nxt = shrd_lvl;
        `OFS_ANA_CFG:   rdata_nxt = ana_cfg_r;
        default:        rdata_nxt = `RDATA_RST;
      endcase
    end
  end

  // First port has no competing output source, so the latch always
  // owns its pads; interrupt pins are input-only functions.
  always @* begin
    first_oe_nxt = port_oe(first_dir_r, `FIRST_IMPL_MASK);
  end

  // Shared port: peripheral wins data and enable while it drives.
  always @* begin
    shrd_own     = periph_en & periph_drive & `SHRD_IMPL_MASK;
    shrd_out_nxt = own_mux(shrd_own, periph_out, shrd_lat_r);
    shrd_oe_nxt  = own_mux(shrd_own, `SHRD_IMPL_MASK,
                           port_oe(shrd_dir_r, `SHRD_IMPL_MASK));
  end

  // First port registers
  always @(posedge ref_clk) begin
    if (rst) begin
      first_dir_r <= `DIR_RST_INPUT & `FIRST_IMPL_MASK;
      first_lat_r <= `LAT_RST;
    end else begin
      first_dir_r <= first_dir_nxt;
      first_lat_r <= first_lat_nxt;
    end
  end

  // Shared port registers
  always @(posedge ref_clk) begin
    if (rst) begin
      shrd_dir_r <= `DIR_RST_INPUT & `SHRD_IMPL_MASK;
      shrd_lat_r <= `LAT_RST;
    end else begin
      shrd_dir_r <= shrd_dir_nxt;
      shrd_lat_r <= shrd_lat_nxt;
    end
  end

  // Analog pin configuration, one bit per shared pin
  always @(posedge ref_clk) begin
    if (rst) begin
      ana_cfg_r <= `ANA_RST;
    end else begin
      ana_cfg_r <= ana_cfg_nxt;
    end
  end

  // Read data, zero outside its one-cycle slot
  always @(posedge ref_clk) begin
    if (rst) begin
      rdata <= `RDATA_RST;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // First port pads trail the latch and direction by one cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      first_pad_out <= `LAT_RST;
      first_pad_oe  <= `PAD_OE_RST;
    end else begin
      first_pad_out <= first_lat_r;
      first_pad_oe  <= first_oe_nxt;
    end
  end

  // Shared port pads, already resolved between peripheral and port
  always @(posedge ref_clk) begin
    if (rst) begin
      shrd_pad_out <= `LAT_RST;
      shrd_pad_oe  <= `PAD_OE_RST;
    end else begin
      shrd_pad_out <= shrd_out_nxt;
      shrd_pad_oe  <= shrd_oe_nxt;
    end
  end

  // Pin stays readable by the peripheral even while the port drives
  always @(posedge ref_clk) begin
    if (rst) begin
      periph_in     <= `PERIPH_IN_RST;
      ext_int_level <= `INT_LVL_RST;
    end else begin
      periph_in     <= shrd_s2_r & `SHRD_IMPL_MASK;
      ext_int_level <= first_s2_r[`FIRST_INT_MSB:`FIRST_INT_LSB];
    end
  end

  // Only analog-configured pins reach the converter; an output-
  // configured analog pin converts its own drive level.
  always @(posedge ref_clk) begin
    if (rst) begin
      analog_route <= `ANA_RST;
    end else begin
      analog_route <= ana_cfg_r;
    end
  end

endmodule // shared_parallel_io_port

`default_nettype wire

/* tb/pio_pad_model.sv */
// Pad cells of one 16-bit port, with an outside driver on every pin.
// Assumes the outside level is always driven, so no pin floats.
`timescale 1ns/1ps
`default_nettype none
module pio_pad_model (
  // Port side
  input wire logic [15:0] oe,
  input wire logic [15:0] dout,
  // Board side and resolved pin
  input wire logic [15:0] ext,
  output logic     [15:0] pin
);
  // Enabled driver wins; the level stays visible to the input path
  assign pin = (oe & dout) | (~oe & ext);
endmodule // pio_pad_model
`default_nettype wire

/* tb/pio_port_asserts.sv */
// Checker for the shared parallel I/O port, bound onto its top module.
// Assumes first port bits 15:14 are absent and reads answer one cycle late.
`timescale 1ns/1ps
`default_nettype none
module pio_port_asserts (
  // Clock, reset and register port
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  // Pads and peripherals
  input wire logic [15:0] first_pad_in,
  input wire logic [15:0] first_pad_out,
  input wire logic [15:0] first_pad_oe,
  input wire logic [15:0] shrd_pad_out,
  input wire logic [15:0] shrd_pad_oe,
  input wire logic [15:0] periph_en,
  input wire logic [15:0] periph_drive,
  input wire logic [15:0] periph_out,
  input wire logic [15:0] analog_route
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] own;
  assign own = periph_en & periph_drive;
  property p_own_oe; 1 |=> (shrd_pad_oe & $past(own)) == $past(own); endproperty
  a_own_oe: assert property (p_own_oe) else $error("owned pad not enabled");
  property p_own_out;
    1 |=> ((shrd_pad_out ^ $past(periph_out)) & $past(own)) == 16'h0000;
  endproperty
  a_own_out: assert property (p_own_out) else $error("owned pad data wrong");
  property p_rd_idle; !$past(rd_stb) |-> rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_absent; first_pad_oe[15:14] == 2'h0 && first_pad_out[15:14] == 2'h0; endproperty
  a_absent: assert property (p_absent) else $error("absent bits active");
  property p_lvl; rd_stb && addr == 8'h04 |=> rdata == ($past(first_pad_in, 3) & 16'h3FFF);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level read not synced pins");
  property p_rst; disable iff (1'b0) rst |=> first_pad_oe == 16'h0000 && shrd_pad_oe == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("pad driven after reset");
  property p_dir; wr_stb && addr == 8'h00 |-> ##2 first_pad_oe == (~$past(wdata, 2) & 16'h3FFF);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_lat; wr_stb && (addr == 8'h02 || addr == 8'h04) |-> ##2
    first_pad_out == ($past(wdata, 2) & 16'h3FFF); endproperty
  a_lat: assert property (p_lat) else $error("latch not on pad");
  property p_ana;
    rd_stb && addr == 8'h0A |=> (rdata & analog_route & $past(analog_route)) == 16'h0000;
  endproperty
  a_ana: assert property (p_ana) else $error("analog pin read high");
endmodule // pio_port_asserts
bind shared_parallel_io_port pio_port_asserts i_chk (.*);
`default_nettype wire

/* tb/shared_parallel_io_port_tb.sv */
// Self-checking bench for the shared parallel I/O port.
// Assumes the pad model and the port map header.
`timescale 1ns/1ps
`include "pio_map.vh"
`default_nettype none
module shared_parallel_io_port_tb;
  logic ref_clk, rst, wr_stb, rd_stb;
  logic [7:0] addr;
  logic [3:0] ext_int_level;
  logic [15:0] wdata, rdata, first_pad_in, first_pad_out, first_pad_oe, shrd_pad_in, shrd_pad_out;
  logic [15:0] shrd_pad_oe, periph_en, periph_drive, periph_out, periph_in, analog_route;
  logic [15:0] ext_a, ext_b, d, l, a, own, oe, pin, pf;
  logic [31:0] seed;
  int err_total = 0, checks_done = 0, cyc = 0;
  shared_parallel_io_port i_dut (.*);
  pio_pad_model i_pad_a (.oe(first_pad_oe), .dout(first_pad_out), .ext(ext_a), .pin(first_pad_in));
  pio_pad_model i_pad_b (.oe(shrd_pad_oe), .dout(shrd_pad_out), .ext(ext_b), .pin(shrd_pad_in));
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [15:0] pin_f(logic [15:0] e, o, x);
    return (e & o) | (~e & x);
  endfunction
  task automatic chk(string nm, logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [15:0] dt);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= ad;
    wdata <= dt;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rc(string nm, logic [7:0] ad, logic [15:0] exp);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= ad;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {wr_stb, rd_stb, addr, wdata, ext_a, ext_b, periph_en, periph_drive, periph_out} = '0;
    rst = 1'b1;
    seed = 32'h0000_E02E;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rc("first_dir", 8'h00, `FIRST_IMPL_MASK);
    rc("shrd_dir", 8'h06, 16'hFFFF);
    rc("unmapped", 8'h0E, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : rnd();
      l = rnd();
      a = rnd() & d;
      wr(8'h00, d);
      wr(8'h04, l);
      wr(8'h06, d);
      wr(8'h08, l);
      wr(8'h0C, a);
      ext_a <= rnd();
      ext_b <= rnd();
      periph_en <= rnd();
      periph_drive <= rnd();
      periph_out <= rnd();
      repeat (6) @(posedge ref_clk);
      #1;
      own = periph_en & periph_drive;
      oe = own | ~d;
      pin = pin_f(oe, pin_f(own, periph_out, l), ext_b);
      pf = pin_f(~d, l, ext_a) & `FIRST_IMPL_MASK;
      chk("shrd_oe", shrd_pad_oe, oe);
      chk("shrd_out", shrd_pad_out, pin_f(own, periph_out, l));
      chk("route", analog_route, a);
      chk("int_lvl", {12'h000, ext_int_level}, {12'h000, pf[11:8]});
      chk("periph_in", periph_in, pin);
      chk("first_oe", first_pad_oe, ~d & `FIRST_IMPL_MASK);
      chk("first_out", first_pad_out, l & `FIRST_IMPL_MASK);
      rc("first_lat", 8'h02, l & `FIRST_IMPL_MASK);
      rc("first_dir", 8'h00, d & `FIRST_IMPL_MASK);
      rc("first_lvl", 8'h04, pf);
      rc("shrd_lvl", 8'h0A, pin & ~a);
      rc("shrd_lat", 8'h08, l);
      rc("shrd_dir", 8'h06, d);
      rc("ana_cfg", 8'h0C, a);
      $display("pattern %0d done", i);
    end
    // Reset again mid-run, with the peripherals still driving
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk("rst_oe", shrd_pad_oe | first_pad_oe, 16'h0000);
    rc("rst_dir", 8'h00, `FIRST_IMPL_MASK);
    rc("rst_sdir", 8'h06, 16'hFFFF);
    rc("rst_lat", 8'h08, 16'h0000);
    rc("rst_ana", 8'h0C, 16'h0000);
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule // shared_parallel_io_port_tb
`default_nettype wire
